// ===== common/hdse_regs.vh
`ifndef HDSE_REGS_VH
`define HDSE_REGS_VH
// Drive kinds.
`define HDSE_DRV_POLE         2'h0
`define HDSE_DRV_VALVE_A      2'h1
`define HDSE_DRV_VALVE_B      2'h2
`define HDSE_DRV_SIMPLE       2'h3
// Pump models steering the fourth contactor.
`define HDSE_PUMP_SOFT        2'h0
`define HDSE_PUMP_STAR_DELTA  2'h1
`define HDSE_PUMP_INVERTER    2'h2
`define HDSE_PUMP_UP_ONLY     2'h3
// Speed classes.
`define HDSE_SPD_CREEP        3'h0
`define HDSE_SPD_SLOW         3'h1
`define HDSE_SPD_MEDIUM       3'h2
`define HDSE_SPD_INTER        3'h3
`define HDSE_SPD_RATED        3'h4
`define HDSE_SPD_INSPECT      3'h5
`define HDSE_SPD_RESCUE       3'h6
`define HDSE_SPD_RELEVEL      3'h7
// Control output bit positions (output n sits at bit n-1).
`define HDSE_OUT1             0
`define HDSE_OUT2             1
`define HDSE_OUT3             2
`define HDSE_OUT4             3
`define HDSE_OUT5             4
`define HDSE_OUT6             5
`define HDSE_OUT7             6
`define HDSE_OUT8             7
// Timing.
`define HDSE_CLK_HZ           125000000
`define HDSE_TICK_US          1000
`define HDSE_TICK_CYCLES      ((`HDSE_CLK_HZ / 1000000) * `HDSE_TICK_US)
`define HDSE_AFTERRUN_OFF     16'h0000
`endif

// ===== src/hdse_ms_timer.v
`timescale 1ns/1ps
`include "hdse_regs.vh"

// After-run timer: counts whole milliseconds once its source falls.
module hdse_ms_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ms_tick,
  input  wire         src_on,
  input  wire         abort,
  input  wire [W-1:0] delay_ms,
  output reg          active
);
  reg [W-1:0] count_reg;
  reg         src_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // A falling source loads the delay; zero delay means the after-run is off.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {W{1'b0}};
      src_d_reg <= 1'b0;
      active    <= 1'b0;
    end else begin
      src_d_reg <= src_on;
      if (src_on || abort) begin
        count_reg <= {W{1'b0}};
        active    <= 1'b0;
      end else if (src_d_reg && delay_ms != {W{1'b0}}) begin
        count_reg <= delay_ms;
        active    <= 1'b1;
      end else if (active && ms_tick) begin
        count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        if (count_reg == {{(W-1){1'b0}}, 1'b1})
          active <= 1'b0;
      end
    end
  end
endmodule // hdse_ms_timer

// ===== src/hdse_encoder.v
`timescale 1ns/1ps
`include "hdse_regs.vh"

// Behaviour
// - Pole-changing motor uses only up, down, fast and slow contactors.
// - Fourth contactor role follows pump model: soft, star-delta, inverter, up-only.
// - With ramp option on, valves stay off until ramp-up done.
// - Readiness input used only when its option is enabled.
// - Simple hydraulics get slow-up valve output with configurable after-run.
// - Pump after-run applies to upward travel only.
// - After-runs are millisecond values, disabled after reset until set.
// - Creep and relevel drive only output 7 up or 8 down.
// - Variant A slow/medium/intermediate: 7+5 or 8+6 plus 1, 2, 3.
// - Variant A rated speed: 7+5 up or 8+6 down only.
// - Variant A inspection and rescue: 7+5+4 up or 8+6+4 down.
// - Variant B slow 7+3 or 8+3; medium 7+5 or 8+6.
// - Variant B inspection and rescue: 7+4 up or 8+4 down.
// - Ten numbered drive control outputs, each routable to any terminal.
// - Variant A safety-valve feedback monitored on its run-state input.
// - Variant B ready, run and pump-up feedbacks each on own input.
// - Pump-up enable feedback used only when its option is enabled.
module hdse_encoder #(
  parameter MS_W     = 16,
  parameter TICK_CYC = `HDSE_TICK_CYCLES
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire [1:0]      drive_kind,
  input  wire [1:0]      pump_model,
  input  wire            ramp_option,
  input  wire            ready_option,
  input  wire            pump_up_option,
  input  wire [MS_W-1:0] slow_up_afterrun_ms,
  input  wire [MS_W-1:0] pump_afterrun_ms,
  input  wire            travel_up,
  input  wire            travel_down,
  input  wire [2:0]      speed_class,
  input  wire            ramp_done_pin,
  input  wire            drive_ready_pin,
  input  wire            safety_valve_feedback_pin,
  input  wire            valve_ready_pin,
  input  wire            pump_up_enable_pin,
  output reg             up_contactor,
  output reg             down_contactor,
  output reg             fast_contactor,
  output reg             aux_pump_contactor,
  output reg  [9:0]      drive_ctrl,
  output reg             slow_up_valve,
  output reg             drive_not_ready,
  output reg             valve_run_state,
  output reg             valve_ready_state,
  output reg             pump_up_blocked
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second stage.
  // The five feedback pins are asynchronous to clk, so each one passes two
  // flip-flops before any decoding logic may look at it.
  localparam NPIN = 5;
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_sync;
  wire            ramp_done_s  = pin_sync[0];
  wire            ready_s      = pin_sync[1];
  wire            sv_run_s     = pin_sync[2];
  wire            sv_ready_s   = pin_sync[3];
  wire            pump_en_s    = pin_sync[4];

  // Lane order fixes which synchroniser carries which feedback pin.
  assign pin_raw = {pump_up_enable_pin, valve_ready_pin,
                    safety_valve_feedback_pin, drive_ready_pin, ramp_done_pin};

  // One two-stage synchroniser per feedback pin.
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp = gp + 1) begin : g_pin_sync
      reg s1_reg;
      reg s2_reg;
      // Reset clears both stages, so no false feedback follows reset.
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= pin_raw[gp];
          s2_reg <= s1_reg;
        end
      end
      assign pin_sync[gp] = s2_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick from the system clock.
  // Both after-run timers share this one divider, so they count in the same
  // millisecond grid. An after-run therefore lasts between its setting minus
  // one and its setting in whole ticks, a phase error the user must allow for.
  // The divider runs freely rather than restarting per stop, which saves a
  // counter per timer at the cost of that phase error.
  localparam TW = 17;
  reg [TW-1:0] tick_cnt_reg;
  reg          ms_tick_reg;

  // Free-running divider; one pulse per millisecond.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= {TW{1'b0}};
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg == TICK_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1}) begin
      tick_cnt_reg <= {TW{1'b0}};
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
      ms_tick_reg  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Travel qualification.
  // Both directions at once is treated as no travel at all, the safe reading
  // of a contradictory request. Readiness and pump-up enable refuse travel
  // only when their options are on; otherwise the pins are ignored, so an
  // unwired input cannot stall the car.
  // The pump-up enable never blocks a pole-changing motor, which has no pump.
  wire is_pole    = (drive_kind == `HDSE_DRV_POLE);
  wire is_var_a   = (drive_kind == `HDSE_DRV_VALVE_A);
  wire is_var_b   = (drive_kind == `HDSE_DRV_VALVE_B);
  wire is_simple  = (drive_kind == `HDSE_DRV_SIMPLE);
  wire both_dir   = travel_up & travel_down;
  wire req_up     = travel_up & ~both_dir;
  wire req_down   = travel_down & ~both_dir;
  // Readiness gates travel only when its option is set.
  wire ready_ok   = ~ready_option | ready_s;
  // The pump-up feedback gates upward hydraulic travel only when enabled.
  wire pump_up_ok = ~pump_up_option | pump_en_s;
  wire go_up      = req_up & ready_ok & (is_pole | pump_up_ok);
  wire go_down    = req_down & ready_ok;
  wire moving     = go_up | go_down;
  // Valves wait for the soft starter ramp when that option is on.
  wire valves_ok  = ~ramp_option | ramp_done_s;
  wire fast_spd   = (speed_class == `HDSE_SPD_MEDIUM) |
                    (speed_class == `HDSE_SPD_INTER)  |
                    (speed_class == `HDSE_SPD_RATED);

  ////////////////////////////////////////////////////////////////////////////
  // Valve encoding for the selected variant, direction and speed.
  // Outputs 7 and 8 carry the direction for every valve block. Variant A
  // adds 5 or 6 as a second direction valve for all but creep and relevel,
  // plus one speed valve out of 1 to 4 except at rated speed. Variant B uses 3, 5 or 6, or 4 on
  // top of the direction output.
  // Speeds that a variant does not map fall back to the bare direction
  // output, the slowest safe choice. The ramp gate clears the whole pattern
  // last, so no valve can open ahead of the soft starter at any speed.
  reg [9:0] code;

  always @* begin
    code = 10'h000;
    if (go_up)
      code[`HDSE_OUT7] = 1'b1;
    if (go_down)
      code[`HDSE_OUT8] = 1'b1;
    if (moving && is_var_a) begin
      case (speed_class)
        `HDSE_SPD_SLOW: begin
          code[`HDSE_OUT5] = go_up;
          code[`HDSE_OUT6] = go_down;
          code[`HDSE_OUT1] = 1'b1;
        end
        `HDSE_SPD_MEDIUM: begin
          code[`HDSE_OUT5] = go_up;
          code[`HDSE_OUT6] = go_down;
          code[`HDSE_OUT2] = 1'b1;
        end
        `HDSE_SPD_INTER: begin
          code[`HDSE_OUT5] = go_up;
          code[`HDSE_OUT6] = go_down;
          code[`HDSE_OUT3] = 1'b1;
        end
        `HDSE_SPD_RATED: begin
          code[`HDSE_OUT5] = go_up;
          code[`HDSE_OUT6] = go_down;
        end
        `HDSE_SPD_INSPECT, `HDSE_SPD_RESCUE: begin
          code[`HDSE_OUT5] = go_up;
          code[`HDSE_OUT6] = go_down;
          code[`HDSE_OUT4] = 1'b1;
        end
        default: begin
          code[`HDSE_OUT1] = 1'b0;
        end
      endcase
    end else if (moving && is_var_b) begin
      case (speed_class)
        `HDSE_SPD_SLOW: begin
          code[`HDSE_OUT3] = 1'b1;
        end
        `HDSE_SPD_MEDIUM: begin
          code[`HDSE_OUT5] = go_up;
          code[`HDSE_OUT6] = go_down;
        end
        `HDSE_SPD_INSPECT, `HDSE_SPD_RESCUE: begin
          code[`HDSE_OUT4] = 1'b1;
        end
        default: begin
          code[`HDSE_OUT1] = 1'b0;
        end
      endcase
    end
    // Pole-changing motors and the simple drive use no numbered outputs.
    if (is_pole || is_simple || !valves_ok)
      code = 10'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // After-run timers.
  // Both timers abort on a down request: the pump must never run on after a
  // downward run, and a slow-up valve held open while descending would fight
  // the down valve.
  wire slow_up_src = go_up & is_simple & ~fast_spd & valves_ok;
  wire pump_src    = go_up & ~is_pole;
  wire slow_up_run;
  wire pump_run;

  // Slow-up valve after-run; a zero setting (reset value) disables it.
  hdse_ms_timer #(.W(MS_W)) u_slow_up_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .ms_tick  (ms_tick_reg),
    .src_on   (slow_up_src),
    .abort    (go_down),
    .delay_ms (slow_up_afterrun_ms),
    .active   (slow_up_run)
  );

  // Pump after-run follows upward travel only; down travel cancels it.
  hdse_ms_timer #(.W(MS_W)) u_pump_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .ms_tick  (ms_tick_reg),
    .src_on   (pump_src),
    .abort    (go_down),
    .delay_ms (pump_afterrun_ms),
    .active   (pump_run)
  );

  // A timer output rises one edge after its source falls, so the edge at
  // which the source drops is bridged here. Without it the contactor or the
  // slow-up valve would drop out for one cycle before the after-run takes over.
  reg  pump_src_d_reg;
  reg  slow_src_d_reg;
  wire pump_load = pump_src_d_reg & ~pump_src & ~go_down &
                   (pump_afterrun_ms != {MS_W{1'b0}});
  wire slow_load = slow_src_d_reg & ~slow_up_src & ~go_down &
                   (slow_up_afterrun_ms != {MS_W{1'b0}});
  wire pump_hold = pump_run | pump_load;
  wire slow_hold = slow_up_run | slow_load;

  // Previous source levels, used only to spot the switch-off edge.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_src_d_reg <= 1'b0;
      slow_src_d_reg <= 1'b0;
    end else begin
      pump_src_d_reg <= pump_src;
      slow_src_d_reg <= slow_up_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fourth contactor role per drive kind and pump model.
  // On a pole-changing motor this contactor is the slow winding. For pumps
  // the star/delta switch is held off until the ramp gate opens, so the
  // motor stays in star while the valves are still shut.
  reg aux_next;

  always @* begin
    aux_next = 1'b0;
    if (is_pole) begin
      aux_next = moving & ~fast_spd;
    end else begin
      case (pump_model)
        `HDSE_PUMP_SOFT:       aux_next = go_up | pump_hold;
        `HDSE_PUMP_STAR_DELTA: aux_next = (go_up | pump_hold) & valves_ok;
        `HDSE_PUMP_INVERTER:   aux_next = moving | pump_hold;
        `HDSE_PUMP_UP_ONLY:    aux_next = go_up | pump_hold;
        default:               aux_next = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; contactors and slow-up valve fall when idle and timers have expired.
  // Every output comes straight from a flip-flop so that pins never show
  // decoding glitches; the cost is one clock of latency, far below any
  // contactor's own switching time.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_contactor       <= 1'b0;
      down_contactor     <= 1'b0;
      fast_contactor     <= 1'b0;
      aux_pump_contactor <= 1'b0;
      slow_up_valve      <= 1'b0;
      drive_not_ready    <= 1'b0;
      valve_run_state    <= 1'b0;
      valve_ready_state  <= 1'b0;
      pump_up_blocked    <= 1'b0;
    end else begin
      up_contactor       <= go_up | pump_hold;
      down_contactor     <= go_down;
      fast_contactor     <= moving & fast_spd;
      aux_pump_contactor <= aux_next;
      slow_up_valve      <= slow_up_src | slow_hold;
      drive_not_ready    <= ready_option & ~ready_s;
      valve_run_state    <= sv_run_s;
      valve_ready_state  <= is_var_b & sv_ready_s;
      pump_up_blocked    <= pump_up_option & ~pump_en_s & req_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Numbered control outputs, one flip-flop per output. Outputs 9 and 10
  // exist for terminal routing, but no mapping here asserts them, so their
  // code bits stay low.
  genvar gc;
  generate
    for (gc = 0; gc < 10; gc = gc + 1) begin : g_ctrl_out
      // Each output falls with its code bit when travel ends.
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          drive_ctrl[gc] <= 1'b0;
        else
          drive_ctrl[gc] <= code[gc];
      end
    end
  endgenerate
endmodule // hdse_encoder

// ===== tb/hdse_encoder_properties.sv
`timescale 1ns/1ps
//////////
// Port-level checks of the encoder's valve patterns and idle state.
module hdse_encoder_properties (
  input wire       clk,
  input wire       rst_n,
  input wire [1:0] drive_kind,
  input wire       ramp_option,
  input wire       ready_option,
  input wire       pump_up_option,
  input wire       travel_up,
  input wire       travel_down,
  input wire [2:0] speed_class,
  input wire       up_contactor,
  input wire       down_contactor,
  input wire [9:0] drive_ctrl,
  input wire       drive_not_ready
);
  // Gating options are off here, so nothing refuses the request.
  wire free = ~ramp_option & ~ready_option & ~pump_up_option;
  wire up   = travel_up & ~travel_down;
  wire dn   = travel_down & ~travel_up;
  wire va   = free & (drive_kind == 2'h1);
  wire vb   = free & (drive_kind == 2'h2);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Each pattern lands one edge after its request.
  AST_POLE_CTRL: assert property (
    drive_kind == 2'h0 |=> drive_ctrl == 10'h000)
    else $error("pole motor drove control outputs");
  AST_POLE_DIR: assert property (
    free && drive_kind == 2'h0 && up |=> up_contactor && !down_contactor)
    else $error("pole motor direction contactors wrong");
  AST_CREEP_UP: assert property (
    (va || vb) && up && (speed_class == 3'h0 || speed_class == 3'h7)
    |=> drive_ctrl == 10'h040)
    else $error("creep or relevel pattern wrong");
  AST_A_SLOW_UP: assert property (
    va && up && speed_class == 3'h1 |=> drive_ctrl == 10'h051)
    else $error("variant a slow pattern wrong");
  AST_A_RATED_DN: assert property (
    va && dn && speed_class == 3'h4 |=> drive_ctrl == 10'h0a0)
    else $error("variant a rated pattern wrong");
  AST_A_INSP_DN: assert property (
    va && dn && speed_class == 3'h5 |=> drive_ctrl == 10'h0a8)
    else $error("variant a inspection pattern wrong");
  AST_B_SLOW_DN: assert property (
    vb && dn && speed_class == 3'h1 |=> drive_ctrl == 10'h084)
    else $error("variant b slow pattern wrong");
  AST_B_RESCUE_UP: assert property (
    vb && up && speed_class == 3'h6 |=> drive_ctrl == 10'h048)
    else $error("variant b rescue pattern wrong");
  AST_IDLE: assert property (
    !up && !dn |=> drive_ctrl == 10'h000)
    else $error("control outputs left on without travel");
  AST_READY_IGN: assert property (
    !ready_option |=> !drive_not_ready)
    else $error("readiness used while its option is off");
endmodule // hdse_encoder_properties

bind hdse_encoder hdse_encoder_properties u_chk (.*);

// ===== tb/hdse_valve_model.sv
`timescale 1ns/1ps
//////////
// Behavioural valve block and pump starter facing the encoder's pins.
module hdse_valve_model (
  input  wire       clk,
  input  wire       aux_pump_contactor,
  input  wire [9:0] drive_ctrl,
  input  wire       model_ready,
  input  wire       model_pump_en,
  output reg        ramp_done_pin,
  output wire       drive_ready_pin,
  output wire       safety_valve_feedback_pin,
  output wire       valve_ready_pin,
  output wire       pump_up_enable_pin
);
  reg [4:0] ramp_cnt;
  initial ramp_cnt = 5'h00;
  initial ramp_done_pin = 1'b0;
  // A slow starter: 20 cycles of pump current before ramp-up is reported.
  always @(posedge clk) begin
    ramp_cnt <= !aux_pump_contactor ? 5'h00 : (ramp_cnt == 5'h14) ? ramp_cnt : ramp_cnt + 5'h01;
    ramp_done_pin <= (ramp_cnt == 5'h14);
  end
  // Readiness is high while ready and low otherwise.
  assign drive_ready_pin           = model_ready;
  assign valve_ready_pin           = model_ready;
  assign pump_up_enable_pin        = model_pump_en;
  assign safety_valve_feedback_pin = |drive_ctrl;
endmodule // hdse_valve_model

// ===== tb/hdse_encoder_test.sv
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
//////////
module hdse_encoder_test;
  reg        clk = 0, rst_n = 0, travel_up = 0, travel_down = 0, u;
  reg        ramp_option = 0, ready_option = 0, pump_up_option = 0;
  reg        model_ready = 1, model_pump_en = 1;
  reg [1:0]  drive_kind = 0, pump_model = 0, k;
  reg [2:0]  speed_class = 0, s;
  reg [15:0] slow_up_afterrun_ms = 0, pump_afterrun_ms = 0;
  wire       up_contactor, down_contactor, fast_contactor, aux_pump_contactor, slow_up_valve;
  wire       drive_not_ready, valve_run_state, valve_ready_state, pump_up_blocked;
  wire       ramp_done_pin, drive_ready_pin, safety_valve_feedback_pin;
  wire       valve_ready_pin, pump_up_enable_pin;
  wire [9:0] drive_ctrl;
  wire [13:0] all_out = {up_contactor, down_contactor, fast_contactor,
                         aux_pump_contactor, drive_ctrl};
  integer    err_count = 0, tests_run = 0, i;
  // One ms tick every 10 cycles keeps after-runs short.
  hdse_encoder #(.TICK_CYC(10)) u_dut (.*);
  hdse_valve_model u_model (.*);
  always #4 clk = ~clk;
  // Expected control outputs for a variant, direction and speed.
  function [9:0] exp_ctrl(input [1:0] kd, input up, input [2:0] sp);
    reg [9:0] d;
    begin
      d = up ? 10'h040 : 10'h080;
      if (kd == 2'h1) begin
        if (sp != 3'h0 && sp != 3'h7) d = d | (up ? 10'h010 : 10'h020);
        case (sp)
          3'h1: d = d | 10'h001;
          3'h2: d = d | 10'h002;
          3'h3: d = d | 10'h004;
          3'h5, 3'h6: d = d | 10'h008;
          default: d = d;
        endcase
      end else if (kd == 2'h2) begin
        case (sp)
          3'h1: d = d | 10'h004;
          3'h2: d = d | (up ? 10'h010 : 10'h020);
          3'h5, 3'h6: d = d | 10'h008;
          default: d = d;
        endcase
      end else d = 10'h000;
      exp_ctrl = d;
    end
  endfunction
  task cyc(input integer n);
    begin repeat (n) @(posedge clk); #1; end
  endtask
  task go(input [1:0] kd, input up, input dn, input [2:0] sp);
    begin drive_kind = kd; travel_up = up; travel_down = dn; speed_class = sp; end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run of a few hundred cycles.
  initial begin
    #200000;
    err_count++;
    complete_run;
  end
  // Main sequence.
  initial begin
    cyc(12);
    rst_n = 1;
    i = $urandom(24);
    // Every pole and valve code in order first, then random requests back to back.
    for (i = 0; i < 120; i++) begin
      if (i < 48) {k, u, s} = i[5:0];
      else begin k = $urandom % 3; u = $urandom % 2; s = $urandom % 8; end
      go(k, u, !u, s);
      cyc(2);
      `CHK(drive_ctrl, exp_ctrl(k, u, s))
      `CHK(drive_ctrl[9:8], 2'b00)
      `CHK({up_contactor, down_contactor}, {u, !u})
      if (k == 2'h0) `CHK(fast_contactor, (s >= 3'h2 && s <= 3'h4))
    end
    $display("test encoding done");
    go(1, 0, 0, 1); cyc(2);
    `CHK(all_out, 14'h0)
    go(1, 1, 1, 1); cyc(2);
    `CHK({up_contactor, down_contactor, drive_ctrl}, 12'h0)
    pump_model = 3; go(1, 0, 1, 1); cyc(2);
    `CHK(aux_pump_contactor, 1'b0)
    go(1, 1, 0, 1); cyc(2);
    `CHK(aux_pump_contactor, 1'b1)
    pump_model = 2; go(1, 0, 1, 1); cyc(2);
    `CHK(aux_pump_contactor, 1'b1)
    pump_model = 1; go(1, 1, 0, 1); cyc(2);
    `CHK(aux_pump_contactor, 1'b1)
    go(1, 0, 1, 1); cyc(2);
    `CHK(aux_pump_contactor, 1'b0)
    pump_model = 0; go(1, 1, 0, 1);
    $display("test idle and pump role done");
    model_ready = 0; ready_option = 1; cyc(5);
    `CHK({drive_not_ready, drive_ctrl}, 11'h400)
    ready_option = 0; cyc(2);
    `CHK({drive_not_ready, drive_ctrl}, 11'h051)
    go(2, 1, 0, 1); cyc(5);
    `CHK(valve_ready_state, 1'b0)
    model_ready = 1; cyc(4);
    `CHK({valve_ready_state, valve_run_state}, 2'b11)
    go(2, 0, 0, 1); cyc(6);
    `CHK(valve_run_state, 1'b0)
    model_pump_en = 0; pump_up_option = 1; go(1, 1, 0, 1); cyc(5);
    `CHK({pump_up_blocked, drive_ctrl}, 11'h400)
    go(1, 0, 1, 1); cyc(2);
    `CHK(drive_ctrl, 10'h0a1)
    pump_up_option = 0; go(1, 1, 0, 1); cyc(2);
    `CHK(drive_ctrl, 10'h051)
    model_pump_en = 1;
    go(1, 0, 0, 1); cyc(2);
    ramp_option = 1; go(1, 1, 0, 1); cyc(10);
    `CHK(drive_ctrl, 10'h000)
    cyc(30);
    `CHK(drive_ctrl, 10'h051)
    ramp_option = 0;
    $display("test gating inputs done");
    pump_afterrun_ms = 2; go(1, 1, 0, 1); cyc(3);
    go(1, 0, 0, 1); cyc(1);
    `CHK({up_contactor, aux_pump_contactor}, 2'b11)
    cyc(7);
    `CHK(up_contactor, 1'b1)
    cyc(30);
    `CHK(up_contactor, 1'b0)
    go(1, 0, 1, 1); cyc(3);
    go(1, 0, 0, 1); cyc(2);
    `CHK({down_contactor, aux_pump_contactor}, 2'b00)
    pump_afterrun_ms = 0; slow_up_afterrun_ms = 3; go(3, 1, 0, 1); cyc(3);
    `CHK(slow_up_valve, 1'b1)
    go(3, 0, 0, 1); cyc(1);
    `CHK(slow_up_valve, 1'b1)
    cyc(14);
    `CHK(slow_up_valve, 1'b1)
    cyc(30);
    `CHK({slow_up_valve, drive_ctrl}, 11'h0)
    $display("test after-runs done");
    go(1, 1, 0, 1); cyc(2);
    rst_n = 0; cyc(1);
    `CHK(all_out, 14'h0)
    rst_n = 1; go(1, 0, 0, 1); cyc(2);
    `CHK(all_out, 14'h0)
    $display("test mid-run reset done");
    complete_run;
  end
endmodule // hdse_encoder_test
